// ---- wdt_pkg.sv ----
// watchdog timer unit: register map, field positions, reset values, timing
// assumes a classic wishbone slave with 32-bit data, byte registers in low bits
package wdt_pkg;
    // register byte addresses (control offset 0xAA is an index, byte address x4)
    localparam logic [7:0] CTL_IDX = 8'hAA;
    localparam logic [9:0] ADDR_CTL = {CTL_IDX, 2'b00};
    localparam logic [9:0] ADDR_CFG4 = 10'h000;
    localparam logic [9:0] ADDR_UNLOCK = 10'h004;
    localparam logic [9:0] ADDR_ISTAT = 10'h008;
    localparam logic [9:0] ADDR_IMASK = 10'h00C;
    localparam logic [9:0] ADDR_SYSCTL = 10'h010;
    // control field positions
    localparam int BIT_RUN = 7;
    localparam int BIT_CLR = 6;
    localparam int BIT_TOF = 5;
    localparam int BIT_LPRUN = 4;
    localparam int BIT_RCF = 3;
    localparam int PS_HI = 2;
    localparam int PS_LO = 0;
    localparam int CFG_MODE_HI = 7;
    localparam int CFG_MODE_LO = 4;
    // system control bits (power state, global and timer interrupt enables)
    localparam int SYS_IDLE = 0;
    localparam int SYS_PDOWN = 1;
    localparam int SYS_GIE = 2;
    localparam int SYS_TIE = 3;
    // status / mask bits
    localparam int EV_TIMEOUT = 0;
    localparam int EV_WDRESET = 1;
    localparam int EV_W = 2;
    // mode codes and reset values
    localparam logic [3:0] MODE_GPT = 4'hF;
    localparam logic [3:0] MODE_STOP_LP = 4'h5;
    localparam logic [7:0] CFG4_RESET = 8'hFF;
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [7:0] SYSCTL_RESET = 8'h00;
    // timed-access unlock key pair
    localparam logic [7:0] KEY_A = 8'hAA;
    localparam logic [7:0] KEY_B = 8'h55;
    // timing
    localparam int CLK_HZ = 100_000_000;
    localparam int LIRC_HZ = 10_000;
    localparam int LIRC_DIV = CLK_HZ / LIRC_HZ;
    localparam int PRE_W = 11;
    // prescaler tap bit of the shortest interval, select code 0
    localparam int PS_TAP_BASE = 4;
    localparam int CNT_W = 6;
    typedef enum logic [1:0] {WDT_LOCKED, WDT_KEY1, WDT_OPEN} wdt_lock_t;
endpackage

// ---- wdt_timer.sv ----
// watchdog timer unit with wishbone register access and interrupt status
// assumes single clock, synchronous inputs, async active-high reset
//
// The Wishbone slave port was left to the implementer.
`timescale 1ns/1ns
// How it works
// RULE1: four-bit mode field picks timer behaviour
// RULE2: unprogrammed config all ones, plain timer
// RULE3: counter advances through divider from 10 kHz
// RULE4: time-out wakes system from low power
// RULE5: reset mode: unfed time-out issues reset later; in low power the wake transition clears delayRun, so no reset follows
// RULE6: run bit only acts in timer mode
// RULE7: counter and prescaler clear on power transitions
// RULE8: counter-clear bit clears counter; feed periodically
// RULE9: run bits software writable in timer mode
// RULE10: interval end sets flag, counting continues
// RULE11: interrupt needs local and global enable; irqOut needs only its maskReg bit, not SYS_GIE
// RULE12: software clears flag then awaits next
// RULE13: control writes need timed-access unlock first
// RULE14: counter-clear bit self-clears after clearing
// RULE15: reset cause flag sticky until software clears
module wdt_timer
    import wdt_pkg::*;
#(
    parameter int TICK_DIV = LIRC_DIV,
    parameter int RESET_DELAY = 512
) (
    // system
    input wire logic clk_sys,
    input wire logic reset,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // system events
    output logic wakeReq,
    output logic sysResetReq,
    output logic timeoutIrq,
    output logic irqOut
);
    logic [7:0] cfgReg;
    logic [7:0] ctlReg;
    logic [7:0] sysReg;
    logic [EV_W-1:0] statReg;
    logic [EV_W-1:0] maskReg;
    wdt_lock_t lockReg;
    logic [$clog2(TICK_DIV+1)-1:0] tickCnt;
    logic [PRE_W-1:0] preReg;
    logic [CNT_W-1:0] cntReg;
    logic [$clog2(RESET_DELAY+1)-1:0] delayCnt;
    logic delayRun;
    logic [1:0] lpPrev;
    logic lowPower;
    logic lpEdge;
    logic [3:0] mode;
    logic isGpt;
    logic running;
    logic tick;
    logic [PRE_W-1:0] tapMask;
    logic step;
    logic interval;
    logic clearAll;
    logic wbReq;
    logic wbWr;
    logic wbRd;
    logic ctlWr;
    logic [7:0] wrByte;

    function automatic logic hit(input logic [9:0] a, input logic [9:0] b);
        hit = (a[9:2] == b[9:2]);
    endfunction

    assign wbReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wbWr = wbReq && wb_we_i && wb_sel_i[0];
    assign wbRd = wbReq && !wb_we_i;
    assign wrByte = wb_dat_i[7:0];
    assign mode = cfgReg[CFG_MODE_HI:CFG_MODE_LO];
    assign isGpt = (mode == MODE_GPT); // RULE1
    assign lowPower = sysReg[SYS_IDLE] | sysReg[SYS_PDOWN];
    assign lpEdge = (lpPrev != {sysReg[SYS_PDOWN], sysReg[SYS_IDLE]});
    // RULE1 RULE6
    assign running = isGpt ? (ctlReg[BIT_RUN] && (!lowPower || ctlReg[BIT_LPRUN]))
                           : !(lowPower && mode == MODE_STOP_LP);
    assign ctlWr = wbWr && hit(wb_adr_i, ADDR_CTL) && lockReg == WDT_OPEN; // RULE13
    // feeding or a power transition wipes the count
    assign clearAll = ctlReg[BIT_CLR] || lpEdge; // RULE7 RULE8
    assign tick = running && (tickCnt == TICK_DIV[$bits(tickCnt)-1:0] - 1'b1); // RULE3
    // counter steps on each carry into the selected tap, so the select sets the interval
    assign tapMask = PRE_W'((1 << (int'(ctlReg[PS_HI:PS_LO]) + PS_TAP_BASE)) - 1);
    assign step = tick && (&(preReg | ~tapMask)); // RULE3
    assign interval = step && (&cntReg[2:0]) && !clearAll;

    // wishbone answers one cycle after the request
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wbReq;
            wb_dat_o <= 32'h0000_0000;
            if (wbRd) begin
                unique case (1'b1)
                    hit(wb_adr_i, ADDR_CTL): wb_dat_o[7:0] <= ctlReg;
                    hit(wb_adr_i, ADDR_CFG4): wb_dat_o[7:0] <= cfgReg;
                    hit(wb_adr_i, ADDR_ISTAT): wb_dat_o[EV_W-1:0] <= statReg;
                    hit(wb_adr_i, ADDR_IMASK): wb_dat_o[EV_W-1:0] <= maskReg;
                    hit(wb_adr_i, ADDR_SYSCTL): wb_dat_o[7:0] <= sysReg;
                    hit(wb_adr_i, ADDR_UNLOCK): wb_dat_o[1:0] <= lockReg;
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // timed access: two keys in a row open one control write
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            lockReg <= WDT_LOCKED;
        end else if (ctlWr) begin
            lockReg <= WDT_LOCKED; // RULE13
        end else if (wbWr && hit(wb_adr_i, ADDR_UNLOCK)) begin
            if (wrByte == KEY_A) begin
                lockReg <= WDT_KEY1;
            end else if (wrByte == KEY_B && lockReg == WDT_KEY1) begin
                lockReg <= WDT_OPEN;
            end else begin
                lockReg <= WDT_LOCKED;
            end
        end
    end

    // boot configuration byte, erased state is all ones
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            cfgReg <= CFG4_RESET; // RULE2
        end else if (wbWr && hit(wb_adr_i, ADDR_CFG4)) begin
            cfgReg <= {wrByte[CFG_MODE_HI:CFG_MODE_LO], 4'h0};
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            sysReg <= SYSCTL_RESET;
            lpPrev <= 2'b00;
        end else begin
            lpPrev <= {sysReg[SYS_PDOWN], sysReg[SYS_IDLE]};
            if (wbWr && hit(wb_adr_i, ADDR_SYSCTL)) begin
                sysReg <= wrByte;
            end else if (interval) begin
                sysReg[SYS_IDLE] <= 1'b0; // RULE4
                sysReg[SYS_PDOWN] <= 1'b0;
            end
        end
    end

    // control register; hardware sets win over software clears
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ctlReg <= CTL_RESET;
        end else begin
            if (ctlWr) begin
                if (isGpt) begin
                    ctlReg[BIT_RUN] <= wrByte[BIT_RUN]; // RULE9
                    ctlReg[BIT_LPRUN] <= wrByte[BIT_LPRUN];
                end
                ctlReg[BIT_CLR] <= wrByte[BIT_CLR]; // RULE8
                ctlReg[BIT_TOF] <= wrByte[BIT_TOF]; // RULE12
                ctlReg[BIT_RCF] <= wrByte[BIT_RCF];
                ctlReg[PS_HI:PS_LO] <= wrByte[PS_HI:PS_LO];
            end else if (ctlReg[BIT_CLR]) begin
                ctlReg[BIT_CLR] <= 1'b0; // RULE14
            end
            if (interval) begin
                ctlReg[BIT_TOF] <= 1'b1; // RULE10
            end
            if (sysResetReq) begin
                ctlReg[BIT_RCF] <= 1'b1; // RULE15
            end
        end
    end

    // divider chain: tick at 10 kHz, prescaler, then counter
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            tickCnt <= '0; // RULE7
            preReg <= '0;
            cntReg <= '0;
        end else if (clearAll || !running) begin
            tickCnt <= '0;
            if (clearAll) begin
                preReg <= '0;
                cntReg <= '0;
            end
        end else if (tick) begin
            tickCnt <= '0;
            preReg <= preReg + 1'b1; // RULE3
            if (step) begin
                cntReg <= cntReg + 1'b1; // RULE10
            end
        end else begin
            tickCnt <= tickCnt + 1'b1;
        end
    end

    // delayed system reset in reset-timer modes
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            delayRun <= 1'b0;
            delayCnt <= '0;
            sysResetReq <= 1'b0;
        end else begin
            sysResetReq <= 1'b0;
            if (clearAll || isGpt) begin
                delayRun <= 1'b0; // RULE8
                delayCnt <= '0;
            end else if (interval && !delayRun) begin
                delayRun <= 1'b1; // RULE5
                delayCnt <= '0;
            end else if (delayRun) begin
                if (delayCnt == RESET_DELAY[$bits(delayCnt)-1:0] - 1'b1) begin
                    sysResetReq <= 1'b1; // RULE5
                    delayRun <= 1'b0;
                    delayCnt <= '0;
                end else begin
                    delayCnt <= delayCnt + 1'b1;
                end
            end
        end
    end

    // interrupt status clears on read; set wins over read clear
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            statReg <= '0;
            maskReg <= '0;
            irqOut <= 1'b0;
            timeoutIrq <= 1'b0;
            wakeReq <= 1'b0;
        end else begin
            if (wbRd && hit(wb_adr_i, ADDR_ISTAT)) begin
                statReg <= {sysResetReq, interval};
            end else begin
                statReg <= statReg | {sysResetReq, interval};
            end
            if (wbWr && hit(wb_adr_i, ADDR_IMASK)) begin
                maskReg <= wrByte[EV_W-1:0];
            end
            irqOut <= |(statReg & maskReg);
            // RULE11
            timeoutIrq <= ctlReg[BIT_TOF] && sysReg[SYS_TIE] && sysReg[SYS_GIE];
            wakeReq <= interval && lowPower; // RULE4
        end
    end

    // assertions
    property p_irq_gate;
        @(posedge clk_sys) disable iff (reset)
        ##1 timeoutIrq |-> $past(sysReg[SYS_GIE]) && $past(sysReg[SYS_TIE]) && $past(ctlReg[BIT_TOF]);
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq without enables"); // RULE11

    property p_flag_set;
        @(posedge clk_sys) disable iff (reset)
        interval |=> ctlReg[BIT_TOF];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set"); // RULE10

    property p_clr_self;
        @(posedge clk_sys) disable iff (reset)
        (ctlReg[BIT_CLR] && !ctlWr) |=> !ctlReg[BIT_CLR] && cntReg == '0;
    endproperty
    a_clr_self: assert property (p_clr_self) else $error("clear bit stuck"); // RULE14

    property p_locked;
        @(posedge clk_sys) disable iff (reset)
        (wbWr && hit(wb_adr_i, ADDR_CTL) && lockReg != WDT_OPEN) |=> $stable(ctlReg[PS_HI:PS_LO]);
    endproperty
    a_locked: assert property (p_locked) else $error("locked write taken"); // RULE13

    property p_no_reset_gpt;
        @(posedge clk_sys) disable iff (reset)
        isGpt |=> !sysResetReq;
    endproperty
    a_no_reset_gpt: assert property (p_no_reset_gpt) else $error("reset in timer mode"); // RULE1

    property p_rcf;
        @(posedge clk_sys) disable iff (reset)
        sysResetReq |=> ctlReg[BIT_RCF];
    endproperty
    a_rcf: assert property (p_rcf) else $error("cause flag missing"); // RULE15

    property p_lp_clear;
        @(posedge clk_sys) disable iff (reset)
        lpEdge |=> cntReg == '0 && preReg == '0;
    endproperty
    a_lp_clear: assert property (p_lp_clear) else $error("no clear on power change"); // RULE7

    property p_wake;
        @(posedge clk_sys) disable iff (reset)
        (interval && lowPower) |=> wakeReq && !lowPower;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake"); // RULE4

    property p_run_stop;
        @(posedge clk_sys) disable iff (reset)
        (isGpt && !ctlReg[BIT_RUN] && !clearAll) |=> $stable(preReg);
    endproperty
    a_run_stop: assert property (p_run_stop) else $error("counts while stopped"); // RULE6

    property p_delay_start;
        @(posedge clk_sys) disable iff (reset)
        (interval && !delayRun && !isGpt) |=> delayRun;
    endproperty
    a_delay_start: assert property (p_delay_start) else $error("delay not started"); // RULE5

    property p_reset_delayed;
        @(posedge clk_sys) disable iff (reset)
        sysResetReq |-> $past(delayRun) && !$past(isGpt);
    endproperty
    a_reset_delayed: assert property (p_reset_delayed) else $error("reset without delay"); // RULE5

    property p_feed_cancels;
        @(posedge clk_sys) disable iff (reset)
        clearAll |=> !delayRun && !sysResetReq;
    endproperty
    a_feed_cancels: assert property (p_feed_cancels) else $error("feed did not cancel"); // RULE8

    property p_gpt_run_wr;
        @(posedge clk_sys) disable iff (reset)
        (isGpt && ctlWr) |=> ctlReg[BIT_RUN] == $past(wrByte[BIT_RUN]);
    endproperty
    a_gpt_run_wr: assert property (p_gpt_run_wr) else $error("run bit not written"); // RULE9

    property p_flag_clear;
        @(posedge clk_sys) disable iff (reset)
        (ctlWr && !wrByte[BIT_TOF] && !interval) |=> !ctlReg[BIT_TOF];
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared"); // RULE12

    property p_irq_level;
        @(posedge clk_sys) disable iff (reset)
        (|(statReg & maskReg)) |=> irqOut;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq missing");

    c_timeout: cover property (@(posedge clk_sys) disable iff (reset) interval);
    c_sysreset: cover property (@(posedge clk_sys) disable iff (reset) sysResetReq);
    c_unlock: cover property (@(posedge clk_sys) disable iff (reset) ctlWr);
    c_irq: cover property (@(posedge clk_sys) disable iff (reset) irqOut);
    c_halt_lp: cover property (@(posedge clk_sys) disable iff (reset) lowPower && mode == MODE_STOP_LP);
endmodule

// ---- testbench.sv ----
// self-checking bench for the watchdog timer unit, wishbone register access
// assumes the design's assertions live in the design files; no separate model
`timescale 1ns/1ns
module testbench
    import wdt_pkg::*;
;
    // clock and reset
    logic clk_sys;
    logic reset;
    // wishbone master
    logic wbCyc;
    logic wbStb;
    logic wbWe;
    logic [9:0] wbAdr;
    logic [3:0] wbSel;
    logic [31:0] wbDatI;
    logic [31:0] wbDatO;
    logic wbAck;
    // events
    logic wakeReq;
    logic sysResetReq;
    logic timeoutIrq;
    logic irqOut;
    int errCount;
    int checksDone;
    logic [31:0] q;

    wdt_timer #(.TICK_DIV(2), .RESET_DELAY(64)) dut (
        .clk_sys(clk_sys),
        .reset(reset),
        .wb_cyc_i(wbCyc),
        .wb_stb_i(wbStb),
        .wb_we_i(wbWe),
        .wb_adr_i(wbAdr),
        .wb_sel_i(wbSel),
        .wb_dat_i(wbDatI),
        .wb_dat_o(wbDatO),
        .wb_ack_o(wbAck),
        .wakeReq(wakeReq),
        .sysResetReq(sysResetReq),
        .timeoutIrq(timeoutIrq),
        .irqOut(irqOut)
    );

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic tally_and_finish();
        if (errCount == 0 && checksDone > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checksDone++;
        if (got !== exp) begin
            errCount++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    // one classic cycle; holds everything until ack is sampled high
    task automatic wb_xfer(input logic [9:0] a, input logic w, input logic [7:0] d,
                           output logic [31:0] rd);
        int n;
        @(posedge clk_sys);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= w;
        wbSel <= 4'h1;
        wbAdr <= a;
        wbDatI <= {24'h000000, d};
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (wbAck !== 1'b1 && n < 50);
        rd = wbDatO;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        if (n >= 50) begin
            chk(32'h00000000, 32'h00000001, "bus answer missing");
            tally_and_finish();
        end
    endtask

    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        logic [31:0] dummy;
        wb_xfer(a, 1'b1, d, dummy);
    endtask

    task automatic rd_chk(input logic [9:0] a, input logic [31:0] exp, input string msg);
        wb_xfer(a, 1'b0, 8'h00, q);
        chk(q, exp, msg);
    endtask

    // control writes need the key pair right before them
    task automatic ctl_wr(input logic [7:0] d);
        wr(ADDR_UNLOCK, KEY_A);
        wr(ADDR_UNLOCK, KEY_B);
        wr(ADDR_CTL, d);
    endtask

    // bounded wait: 0 timeout irq, 1 system reset request, 2 wake request
    task automatic wait_hi(input int sel, input int lim);
        int n;
        logic s;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
            s = (sel == 0) ? timeoutIrq : (sel == 1) ? sysResetReq : wakeReq;
        end while (s !== 1'b1 && n < lim);
        if (n >= lim) begin
            chk(32'h00000000, 32'h00000001, "event never came");
            tally_and_finish();
        end
    endtask

    initial begin
        errCount = 0;
        checksDone = 0;
        reset = 1'b1;
        wbCyc = 1'b0;
        wbStb = 1'b0;
        wbWe = 1'b0;
        wbAdr = 10'h000;
        wbSel = 4'h1;
        wbDatI = 32'h00000000;
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        rd_chk(ADDR_CFG4, {24'h000000, CFG4_RESET}, "config reset");
        rd_chk(ADDR_CTL, {24'h000000, CTL_RESET}, "control reset");
        rd_chk(10'h3FC, 32'h00000000, "unmapped read");
        wr(ADDR_CTL, 8'h80);
        rd_chk(ADDR_CTL, 32'h00000000, "locked write ignored");
        wr(ADDR_SYSCTL, 8'h0D);
        wr(ADDR_IMASK, 8'h01);
        // idle is already set, so the lowpower run bit is needed to count
        ctl_wr(8'h90);
        rd_chk(ADDR_CTL, 32'h00000090, "run and lowpower run set");
        wait_hi(2, 20000);
        wait_hi(0, 20);
        chk({31'h0, irqOut}, 32'h00000001, "masked-in status drives irq");
        rd_chk(ADDR_CTL, 32'h000000B0, "flag set, still running");
        rd_chk(ADDR_SYSCTL, 32'h0000000C, "wake clears idle");
        rd_chk(ADDR_ISTAT, 32'h00000001, "status timeout bit");
        rd_chk(ADDR_ISTAT, 32'h00000000, "status cleared by read");
        chk({31'h0, irqOut}, 32'h00000000, "irq drops after status read");
        ctl_wr(8'h80);
        rd_chk(ADDR_CTL, 32'h00000080, "flag cleared, lp run writable");
        chk({31'h0, timeoutIrq}, 32'h00000000, "timeout irq follows flag");
        ctl_wr(8'hC0);
        rd_chk(ADDR_CTL, 32'h00000080, "clear bit self-clears");
        // counting goes on after a time-out, so the next one arrives
        wait_hi(0, 600);
        ctl_wr(8'h00);
        rd_chk(ADDR_CTL, 32'h00000000, "run bit cleared");
        rd_chk(ADDR_ISTAT, 32'h00000001, "second timeout in status");
        repeat (600) @(posedge clk_sys);
        rd_chk(ADDR_ISTAT, 32'h00000000, "stopped timer stays silent");
        // reset mode: no feeding, so the delayed reset must follow
        wr(ADDR_CFG4, 8'h00);
        rd_chk(ADDR_CFG4, 32'h00000000, "config writable");
        wait_hi(1, 40000);
        wb_xfer(ADDR_ISTAT, 1'b0, 8'h00, q);
        chk(q & 32'h00000002, 32'h00000002, "reset event in status");
        wb_xfer(ADDR_CTL, 1'b0, 8'h00, q);
        chk(q & 32'h00000008, 32'h00000008, "reset cause flag set");
        // feeds well inside the interval keep the reset away
        repeat (40) ctl_wr(8'h40);
        rd_chk(ADDR_ISTAT, 32'h00000000, "fed watchdog stays quiet");
        rd_chk(ADDR_CTL, 32'h00000000, "cause flag cleared by write");
        // halting reset mode stops in idle, the other reset modes run on
        wr(ADDR_CFG4, 8'h50);
        wr(ADDR_SYSCTL, 8'h01);
        repeat (700) @(posedge clk_sys);
        rd_chk(ADDR_ISTAT, 32'h00000000, "halted in idle");
        wr(ADDR_CFG4, 8'h00);
        wait_hi(2, 1000);
        @(posedge clk_sys);
        chk({31'h0, timeoutIrq}, 32'h00000000, "no irq without enables");
        wb_xfer(ADDR_CTL, 1'b0, 8'h00, q);
        chk(q & 32'h00000020, 32'h00000020, "flag set in reset mode");
        tally_and_finish();
    end
endmodule
